// File: logic/dtc_params.svh
// offsets, field positions, reset values and timing counts of the timers
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// register byte offsets on the bus
`define DTC_OFS_CTRL     8'h00
`define DTC_OFS_MODE     8'h04
`define DTC_OFS_T0_LOW   8'h08
`define DTC_OFS_T0_HIGH  8'h0C
`define DTC_OFS_T1_LOW   8'h10
`define DTC_OFS_T1_HIGH  8'h14

// control register fields
`define DTC_CTL_OVF1  7
`define DTC_CTL_RUN1  6
`define DTC_CTL_OVF0  5
`define DTC_CTL_RUN0  4
`define DTC_CTL_IE1   3
`define DTC_CTL_IT1   2
`define DTC_CTL_IE0   1
`define DTC_CTL_IT0   0

// mode register fields, per unit nibble
`define DTC_MODE_GATE  3
`define DTC_MODE_CT    2
`define DTC_MODE_M_HI  1
`define DTC_MODE_M_LO  0
`define DTC_MODE_U1_LSB 4
`define DTC_MODE_U0_LSB 0

// reset values
`define DTC_CTRL_RST  8'h00
`define DTC_MODE_RST  8'h00
`define DTC_CNT_RST   8'h00

// timing: clock period and machine cycle in ns, cycles per machine cycle
`define DTC_CLK_PERIOD_NS   50
`define DTC_MACH_CYCLE_NS   600
`define DTC_MACH_DIV        (`DTC_MACH_CYCLE_NS / `DTC_CLK_PERIOD_NS)

`endif

// File: logic/dtc_pkg.sv
// types shared by the dual timer/counter
package dtc_pkg;

  // counting modes, encoded as the two mode-select bits
  typedef enum logic [1:0] {
    DTC_MODE_13BIT  = 2'b00,
    DTC_MODE_16BIT  = 2'b01,
    DTC_MODE_RELOAD = 2'b10,
    DTC_MODE_SPLIT  = 2'b11
  } dtc_mode_t;

  // bus slave data-phase states
  typedef enum logic [1:0] {
    DTC_BUS_IDLE   = 2'b00,
    DTC_BUS_RDWAIT = 2'b01,
    DTC_BUS_RDDONE = 2'b11,
    DTC_BUS_WRITE  = 2'b10
  } dtc_bus_state_t;

endpackage : dtc_pkg

// File: logic/dtc_timer_top.sv
// dual timer/counter with control, mode and count registers on AHB-Lite
`timescale 1ns/1ps
`include "dtc_params.svh"

module dtc_timer_top
  import dtc_pkg::*;
#(
  parameter int MACH_DIV = `DTC_MACH_DIV
) (
  input  wire logic        CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        FIRST_UNIT_COUNT_PIN_IN,
  input  wire logic        SECOND_UNIT_COUNT_PIN_IN,
  input  wire logic        EXT_IRQ_A_PIN_IN,
  input  wire logic        EXT_IRQ_B_PIN_IN,
  input  wire logic        FIRST_OVF_ACK_IN,
  input  wire logic        SECOND_OVF_ACK_IN,
  input  wire logic        EXT_IRQ_A_ACK_IN,
  input  wire logic        EXT_IRQ_B_ACK_IN,
  output logic             FIRST_OVF_FLAG_OUT,
  output logic             SECOND_OVF_FLAG_OUT,
  output logic             EXT_IRQ_A_FLAG_OUT,
  output logic             EXT_IRQ_B_FLAG_OUT
);

  // the divider needs at least two clocks per machine cycle,
  // and its 8-bit counter caps the ratio at 255
  if (MACH_DIV < 2 || MACH_DIV > 255) begin : g_bad_div
    $error("MACH_DIV must lie between 2 and 255");
  end

  // one count step: {overflow, high byte, low byte}
  function automatic logic [16:0] dtc_step(input dtc_mode_t mode,
                                           input logic [7:0] hi,
                                           input logic [7:0] lo);
    logic [13:0] s13;
    logic [16:0] s16;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    case (mode)
      // upper three low bits just ride along unchanged
      DTC_MODE_13BIT: begin
        dtc_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      end
      DTC_MODE_16BIT:  dtc_step = s16;
      DTC_MODE_RELOAD: begin
        if (lo == 8'hFF) begin
          dtc_step = {1'b1, hi, hi};
        end else begin
          dtc_step = {1'b0, hi, lo + 8'h01};
        end
      end
      default:         dtc_step = {1'b0, hi, lo};
    endcase
  endfunction : dtc_step

  // register index decode, shared by read and write paths
  function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
    is_reg = (a == ofs);
  endfunction : is_reg

  // bus state and captured address phase
  dtc_bus_state_t bus_st_q;
  dtc_bus_state_t bus_st_d;
  logic [7:0]     addr_q;
  logic [31:0]    rdata_q;
  logic [7:0]     rd_mux;
  logic           accept;
  logic           wr_en;

  // control, mode and count storage
  logic           ovf1_q;
  logic           run1_q;
  logic           ovf0_q;
  logic           run0_q;
  logic           ie1_q;
  logic           it1_q;
  logic           ie0_q;
  logic           it0_q;
  logic [7:0]     mode_q;
  logic [7:0]     tl0_q;
  logic [7:0]     th0_q;
  logic [7:0]     tl1_q;
  logic [7:0]     th1_q;

  // machine-cycle divider and pin samples
  logic [7:0]     div_q;
  logic           tick;
  logic           cnt0_smp_q;
  logic           cnt1_smp_q;
  logic           irq_a_smp_q;
  logic           irq_b_smp_q;

  // counting datapath
  dtc_mode_t      mode0;
  dtc_mode_t      mode1;
  logic           gate0;
  logic           gate1;
  logic           ct0;
  logic           ct1;
  logic           split;
  logic           inc0;
  logic           inc1;
  logic           inc_th0;
  logic           run1_eff;
  logic [16:0]    step0;
  logic [16:0]    step1;
  logic [7:0]     tl0_nx;
  logic [7:0]     th0_nx;
  logic [7:0]     tl1_nx;
  logic [7:0]     th1_nx;
  logic           set_ovf0;
  logic           set_ovf1;
  logic           set_ie0;
  logic           set_ie1;
  logic           wr_ctrl;

  // address phase is taken when selected, NONSEQ or SEQ (HTRANS bit 1 set) and bus ready
  assign accept = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
  assign wr_en  = (bus_st_q == DTC_BUS_WRITE);
  assign wr_ctrl = wr_en && is_reg(addr_q, `DTC_OFS_CTRL);

  // reads take one wait state so a write just before is visible
  always_comb begin
    case (bus_st_q)
      DTC_BUS_RDWAIT: bus_st_d = DTC_BUS_RDDONE;
      default: begin
        if (accept) begin
          bus_st_d = HWRITE_IN ? DTC_BUS_WRITE : DTC_BUS_RDWAIT;
        end else begin
          bus_st_d = DTC_BUS_IDLE;
        end
      end
    endcase
  end

  // bus state register and latched address
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      bus_st_q <= DTC_BUS_IDLE;
      addr_q   <= 8'h00;
    end else begin
      bus_st_q <= bus_st_d;
      if (accept && bus_st_q != DTC_BUS_RDWAIT) begin
        addr_q <= HADDR_IN[7:0];
      end
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    if (is_reg(addr_q, `DTC_OFS_CTRL)) begin
      rd_mux = {ovf1_q, run1_q, ovf0_q, run0_q, ie1_q, it1_q, ie0_q, it0_q};
    end else if (is_reg(addr_q, `DTC_OFS_MODE)) begin
      rd_mux = mode_q;
    end else if (is_reg(addr_q, `DTC_OFS_T0_LOW)) begin
      rd_mux = tl0_q;
    end else if (is_reg(addr_q, `DTC_OFS_T0_HIGH)) begin
      rd_mux = th0_q;
    end else if (is_reg(addr_q, `DTC_OFS_T1_LOW)) begin
      rd_mux = tl1_q;
    end else if (is_reg(addr_q, `DTC_OFS_T1_HIGH)) begin
      rd_mux = th1_q;
    end
  end

  // read data captured during the wait cycle
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      rdata_q <= 32'h0000_0000;
    end else if (bus_st_q == DTC_BUS_RDWAIT) begin
      rdata_q <= {24'h00_0000, rd_mux};
    end
  end

  assign HRDATA_OUT    = rdata_q;
  assign HREADYOUT_OUT = (bus_st_q != DTC_BUS_RDWAIT);
  assign HRESP_OUT     = 1'b0;

  // machine-cycle enable: one pulse per MACH_DIV clocks
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      div_q <= 8'h00;
    end else if (div_q == 8'(MACH_DIV - 1)) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign tick = (div_q == 8'(MACH_DIV - 1));

  // pins sampled once per machine cycle
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      cnt0_smp_q  <= 1'b0;
      cnt1_smp_q  <= 1'b0;
      irq_a_smp_q <= 1'b0;
      irq_b_smp_q <= 1'b0;
    end else if (tick) begin
      cnt0_smp_q  <= FIRST_UNIT_COUNT_PIN_IN;
      cnt1_smp_q  <= SECOND_UNIT_COUNT_PIN_IN;
      irq_a_smp_q <= EXT_IRQ_A_PIN_IN;
      irq_b_smp_q <= EXT_IRQ_B_PIN_IN;
    end
  end

  // mode register fields per unit
  assign mode0 = dtc_mode_t'(mode_q[`DTC_MODE_U0_LSB +: 2]);
  assign mode1 = dtc_mode_t'(mode_q[`DTC_MODE_U1_LSB +: 2]);
  assign ct0   = mode_q[`DTC_MODE_U0_LSB + `DTC_MODE_CT];
  assign ct1   = mode_q[`DTC_MODE_U1_LSB + `DTC_MODE_CT];
  assign gate0 = mode_q[`DTC_MODE_U0_LSB + `DTC_MODE_GATE];
  assign gate1 = mode_q[`DTC_MODE_U1_LSB + `DTC_MODE_GATE];
  assign split = (mode0 == DTC_MODE_SPLIT);

  // increment qualifiers: run, gate, and cycle or pin falling edge
  assign inc0 = tick && run0_q && (!gate0 || EXT_IRQ_A_PIN_IN)
             && (ct0 ? (cnt0_smp_q && !FIRST_UNIT_COUNT_PIN_IN)
                     : 1'b1);
  // a split first unit takes over the second run bit, so the second unit
  // then runs on its mode alone and stops only in its own split mode
  assign run1_eff = split || run1_q;
  assign inc1 = tick && run1_eff && (!gate1 || EXT_IRQ_B_PIN_IN)
             && (ct1 ? (cnt1_smp_q && !SECOND_UNIT_COUNT_PIN_IN)
                     : 1'b1);
  // split high byte counts cycles under the second run bit only
  assign inc_th0 = tick && run1_q;

  assign step0 = dtc_step(mode0, th0_q, tl0_q);
  assign step1 = dtc_step(mode1, th1_q, tl1_q);

  // next counts of the first unit, split or joined
  always_comb begin
    tl0_nx   = tl0_q;
    th0_nx   = th0_q;
    set_ovf0 = 1'b0;
    set_ovf1 = 1'b0;
    if (split) begin
      if (inc0) begin
        tl0_nx   = tl0_q + 8'h01;
        set_ovf0 = (tl0_q == 8'hFF);
      end
      if (inc_th0) begin
        th0_nx   = th0_q + 8'h01;
        set_ovf1 = (th0_q == 8'hFF);
      end
    end else if (inc0) begin
      tl0_nx   = step0[7:0];
      th0_nx   = step0[15:8];
      set_ovf0 = step0[16];
    end
    // second unit keeps counting but loses its flag while split
    if (!split) begin
      set_ovf1 = inc1 && step1[16];
    end
  end

  // the second unit holds in its own split mode via the step function
  assign tl1_nx = inc1 ? step1[7:0]  : tl1_q;
  assign th1_nx = inc1 ? step1[15:8] : th1_q;

  // count bytes; a bus write wins over the same-cycle increment
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      tl0_q <= `DTC_CNT_RST;
      th0_q <= `DTC_CNT_RST;
      tl1_q <= `DTC_CNT_RST;
      th1_q <= `DTC_CNT_RST;
    end else begin
      tl0_q <= (wr_en && is_reg(addr_q, `DTC_OFS_T0_LOW))
               ? HWDATA_IN[7:0] : tl0_nx;
      th0_q <= (wr_en && is_reg(addr_q, `DTC_OFS_T0_HIGH))
               ? HWDATA_IN[7:0] : th0_nx;
      tl1_q <= (wr_en && is_reg(addr_q, `DTC_OFS_T1_LOW))
               ? HWDATA_IN[7:0] : tl1_nx;
      th1_q <= (wr_en && is_reg(addr_q, `DTC_OFS_T1_HIGH))
               ? HWDATA_IN[7:0] : th1_nx;
    end
  end

  // mode register, fully software owned
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      mode_q <= `DTC_MODE_RST;
    end else if (wr_en && is_reg(addr_q, `DTC_OFS_MODE)) begin
      mode_q <= HWDATA_IN[7:0];
    end
  end

  // run and trigger-type bits; writing run never touches counts
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      run1_q <= 1'b0;
      run0_q <= 1'b0;
      it1_q  <= 1'b0;
      it0_q  <= 1'b0;
    end else if (wr_ctrl) begin
      run1_q <= HWDATA_IN[`DTC_CTL_RUN1];
      run0_q <= HWDATA_IN[`DTC_CTL_RUN0];
      it1_q  <= HWDATA_IN[`DTC_CTL_IT1];
      it0_q  <= HWDATA_IN[`DTC_CTL_IT0];
    end
  end

  // external requests: falling edge or low level per trigger type
  assign set_ie0 = tick && (it0_q ? (irq_a_smp_q && !EXT_IRQ_A_PIN_IN)
                                  : !EXT_IRQ_A_PIN_IN);
  assign set_ie1 = tick && (it1_q ? (irq_b_smp_q && !EXT_IRQ_B_PIN_IN)
                                  : !EXT_IRQ_B_PIN_IN);

  // overflow flags: cleared by vector ack or write, hardware set wins
  // so an overflow in the clearing cycle is never lost
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ovf1_q <= 1'b0;
      ovf0_q <= 1'b0;
    end else begin
      if (set_ovf1) begin
        ovf1_q <= 1'b1;
      end else if (wr_ctrl) begin
        ovf1_q <= HWDATA_IN[`DTC_CTL_OVF1];
      end else if (SECOND_OVF_ACK_IN) begin
        ovf1_q <= 1'b0;
      end
      if (set_ovf0) begin
        ovf0_q <= 1'b1;
      end else if (wr_ctrl) begin
        ovf0_q <= HWDATA_IN[`DTC_CTL_OVF0];
      end else if (FIRST_OVF_ACK_IN) begin
        ovf0_q <= 1'b0;
      end
    end
  end

  // edge flags: a level request sets again on every tick the pin stays
  // low, so an ack during a held level is overruled on purpose
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      ie1_q <= 1'b0;
      ie0_q <= 1'b0;
    end else begin
      if (set_ie1) begin
        ie1_q <= 1'b1;
      end else if (wr_ctrl) begin
        ie1_q <= HWDATA_IN[`DTC_CTL_IE1];
      end else if (EXT_IRQ_B_ACK_IN) begin
        ie1_q <= 1'b0;
      end
      if (set_ie0) begin
        ie0_q <= 1'b1;
      end else if (wr_ctrl) begin
        ie0_q <= HWDATA_IN[`DTC_CTL_IE0];
      end else if (EXT_IRQ_A_ACK_IN) begin
        ie0_q <= 1'b0;
      end
    end
  end

  // flags go straight to the interrupt controller
  assign FIRST_OVF_FLAG_OUT  = ovf0_q;
  assign SECOND_OVF_FLAG_OUT = ovf1_q;
  assign EXT_IRQ_A_FLAG_OUT  = ie0_q;
  assign EXT_IRQ_B_FLAG_OUT  = ie1_q;

endmodule : dtc_timer_top

// File: verification/dtc_pin_model.sv
// far-side source of falling edges for one count pin
`timescale 1ns/1ps
module dtc_pin_model #(
  parameter int HOLD = 6
) (
  input  wire logic       clk_in,
  input  wire logic       start_in,
  input  wire logic [7:0] pulses_in,
  output logic            pin_out,
  output logic            busy_out
);
  logic [7:0] left_q;
  int         cnt_q;
  initial begin
    pin_out = 1'b1;
    left_q = 8'h00;
    cnt_q = 0;
  end
  assign busy_out = (left_q != 8'h00);
  // idles high; each level is held longer than one machine cycle so the
  // sampler cannot miss it
  always @(posedge clk_in) begin
    if (start_in) begin
      left_q <= pulses_in;
      cnt_q <= 0;
    end else if (busy_out) begin
      if (cnt_q == HOLD - 1) begin
        cnt_q <= 0;
        pin_out <= ~pin_out;
        if (!pin_out) begin
          left_q <= left_q - 8'h01;
        end
      end else begin
        cnt_q <= cnt_q + 1;
      end
    end
  end
endmodule : dtc_pin_model

// File: verification/dtc_timer_monitor.sv
// bus timing and flag cause checks on the timer block ports
`timescale 1ns/1ps
module dtc_timer_monitor #(
  parameter int MACH_DIV = 12
) (
  input wire logic        CLK_IN,
  input wire logic        SRST_IN,
  input wire logic        HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0]  HTRANS_IN,
  input wire logic        HWRITE_IN,
  input wire logic        HREADY_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        EXT_IRQ_A_PIN_IN,
  input wire logic        FIRST_OVF_ACK_IN,
  input wire logic        SECOND_OVF_ACK_IN,
  input wire logic        FIRST_OVF_FLAG_OUT,
  input wire logic        SECOND_OVF_FLAG_OUT,
  input wire logic        EXT_IRQ_A_FLAG_OUT
);
  logic taken;
  logic wr_ctrl_q;
  default clocking cb @(posedge CLK_IN); endclocking
  assign taken = HSEL_IN & HTRANS_IN[1] & HREADY_IN;
  // marks the data phase of a control write, the only software flag clear
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      wr_ctrl_q <= 1'b0;
    end else if (HREADY_IN) begin
      wr_ctrl_q <= taken & HWRITE_IN & (HADDR_IN[7:0] == 8'h00);
    end
  end
  property p_reset;
    SRST_IN |=> !FIRST_OVF_FLAG_OUT && !SECOND_OVF_FLAG_OUT &&
      !EXT_IRQ_A_FLAG_OUT && HREADYOUT_OUT && HRDATA_OUT == 32'h00000000;
  endproperty
  a_reset: assert property (p_reset) else $error("bad reset state");
  property p_rd_wait;
    disable iff (SRST_IN) taken && !HWRITE_IN |=>
      !HREADYOUT_OUT ##1 HREADYOUT_OUT;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_ready;
    disable iff (SRST_IN) taken && HWRITE_IN |=> HREADYOUT_OUT;
  endproperty
  a_wr_ready: assert property (p_wr_ready) else $error("write stalled");
  property p_unmapped;
    disable iff (SRST_IN) taken && !HWRITE_IN && HADDR_IN[7:0] > 8'h14
      |=> ##1 HRDATA_OUT == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
  property p_okay;
    disable iff (SRST_IN) HRESP_OUT == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_fall0;
    disable iff (SRST_IN) $fell(FIRST_OVF_FLAG_OUT) |->
      $past(FIRST_OVF_ACK_IN) || $past(wr_ctrl_q) || $past(SRST_IN);
  endproperty
  a_fall0: assert property (p_fall0) else $error("flag0 fell");
  property p_fall1;
    disable iff (SRST_IN) $fell(SECOND_OVF_FLAG_OUT) |->
      $past(SECOND_OVF_ACK_IN) || $past(wr_ctrl_q) || $past(SRST_IN);
  endproperty
  a_fall1: assert property (p_fall1) else $error("flag1 fell");
  // the pin may pass a sampler and a tick before the flag is set
  property p_rise_a;
    disable iff (SRST_IN) $rose(EXT_IRQ_A_FLAG_OUT) |->
      !$past(EXT_IRQ_A_PIN_IN) || !$past(EXT_IRQ_A_PIN_IN, 2) ||
      !$past(EXT_IRQ_A_PIN_IN, 3) || !$past(EXT_IRQ_A_PIN_IN, 4) ||
      $past(wr_ctrl_q);
  endproperty
  a_rise_a: assert property (p_rise_a) else $error("irq flag rose");
endmodule : dtc_timer_monitor

bind dtc_timer_top dtc_timer_monitor #(.MACH_DIV(MACH_DIV)) mon_u (
  .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .HSEL_IN(HSEL_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .EXT_IRQ_A_PIN_IN(EXT_IRQ_A_PIN_IN), .FIRST_OVF_ACK_IN(FIRST_OVF_ACK_IN),
  .SECOND_OVF_ACK_IN(SECOND_OVF_ACK_IN),
  .FIRST_OVF_FLAG_OUT(FIRST_OVF_FLAG_OUT),
  .SECOND_OVF_FLAG_OUT(SECOND_OVF_FLAG_OUT),
  .EXT_IRQ_A_FLAG_OUT(EXT_IRQ_A_FLAG_OUT)
);

// File: verification/dual_timer_counter_tb.sv
// register-level tests of the dual timer/counter
`timescale 1ns/1ps
`include "dtc_params.svh"
module dual_timer_counter_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic [31:0] hrdata;
  logic        hready;
  logic [1:0]  cpin;
  logic [1:0]  busy;
  logic [1:0]  start = 2'b00;
  logic        irq_a = 1'b1;
  logic        irq_b = 1'b1;
  logic [3:0]  ack = 4'h0;
  logic [3:0]  flag;
  logic [7:0]  r;
  logic [7:0]  r2;
  int          fails = 0;
  int          n_checks = 0;
  always #25 clk = ~clk;
  // a short machine cycle keeps the overflow waits brief
  dtc_timer_top #(.MACH_DIV(2)) dut_u (
    .CLK_IN(clk), .SRST_IN(srst), .HSEL_IN(hsel), .HADDR_IN(haddr),
    .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
    .HREADYOUT_OUT(hready), .HRESP_OUT(),
    .FIRST_UNIT_COUNT_PIN_IN(cpin[0]), .SECOND_UNIT_COUNT_PIN_IN(cpin[1]),
    .EXT_IRQ_A_PIN_IN(irq_a), .EXT_IRQ_B_PIN_IN(irq_b),
    .FIRST_OVF_ACK_IN(ack[0]), .SECOND_OVF_ACK_IN(ack[1]),
    .EXT_IRQ_A_ACK_IN(ack[2]), .EXT_IRQ_B_ACK_IN(ack[3]),
    .FIRST_OVF_FLAG_OUT(flag[0]), .SECOND_OVF_FLAG_OUT(flag[1]),
    .EXT_IRQ_A_FLAG_OUT(flag[2]), .EXT_IRQ_B_FLAG_OUT(flag[3])
  );
  dtc_pin_model pin0_u (.clk_in(clk), .start_in(start[0]),
    .pulses_in(8'h03), .pin_out(cpin[0]), .busy_out(busy[0]));
  dtc_pin_model pin1_u (.clk_in(clk), .start_in(start[1]),
    .pulses_in(8'h05), .pin_out(cpin[1]), .busy_out(busy[1]));

  task final_report;
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one single transfer; entered just after a rising edge
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= {24'h000000, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata[7:0];
  endtask : xfer
  task wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  task rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    chk(r, e);
  endtask : rdc
  // read until a bit sets, bounded
  task poll(input logic [7:0] a, input int b);
    r = 8'h00;
    for (int i = 0; i < 300 && r[b] !== 1'b1; i++) xfer(1'b0, a, 8'h00);
  endtask : poll
  task pulse(input int i);
    ack[i] <= 1'b1;
    @(posedge clk);
    ack[i] <= 1'b0;
    @(posedge clk);
  endtask : pulse
  task clear_counts;
    for (int i = 2; i < 6; i++) wr(8'(i * 4), 8'h00);
  endtask : clear_counts

  initial begin
    repeat (30000) @(posedge clk);
    fails++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 6; i++) rdc(8'(i * 4), 8'h00);
    wr(`DTC_OFS_MODE, 8'hA5);
    rdc(`DTC_OFS_MODE, 8'hA5);
    wr(8'h18, 8'h5A);
    rdc(8'h18, 8'h00);
    // 16-bit: two ticks from the top of the count
    wr(`DTC_OFS_T0_LOW, 8'hFE);
    wr(`DTC_OFS_T0_HIGH, 8'hFF);
    wr(`DTC_OFS_MODE, 8'h01);
    wr(`DTC_OFS_CTRL, 8'h10);
    poll(`DTC_OFS_CTRL, 5);
    chk({7'h0, flag[0]}, 8'h01);
    pulse(0);
    chk({7'h0, flag[0]}, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h00);
    rdc(`DTC_OFS_T0_HIGH, 8'h00);
    xfer(1'b0, `DTC_OFS_T0_LOW, 8'h00);
    r2 = r;
    repeat (10) @(posedge clk);
    rdc(`DTC_OFS_T0_LOW, r2);
    // 13-bit: carry leaves bit 4 of the low byte
    wr(`DTC_OFS_T1_LOW, 8'hFF);
    wr(`DTC_OFS_T1_HIGH, 8'h00);
    wr(`DTC_OFS_MODE, 8'h00);
    wr(`DTC_OFS_CTRL, 8'h40);
    r = 8'h00;
    for (int i = 0; i < 50 && r === 8'h00; i++) begin
      xfer(1'b0, `DTC_OFS_T1_HIGH, 8'h00);
    end
    chk(r, 8'h01);
    xfer(1'b0, `DTC_OFS_T1_LOW, 8'h00);
    chk(r & 8'hE0, 8'hE0);
    // auto-reload
    wr(`DTC_OFS_T0_LOW, 8'hFE);
    wr(`DTC_OFS_T0_HIGH, 8'hF0);
    wr(`DTC_OFS_MODE, 8'h02);
    wr(`DTC_OFS_CTRL, 8'h10);
    poll(`DTC_OFS_CTRL, 5);
    chk({7'h0, r[5]}, 8'h01);
    wr(`DTC_OFS_CTRL, 8'h00);
    rdc(`DTC_OFS_T0_HIGH, 8'hF0);
    xfer(1'b0, `DTC_OFS_T0_LOW, 8'h00);
    chk({7'h0, r >= 8'hF0}, 8'h01);
    // gate held low blocks counting; level trigger
    irq_a <= 1'b0;
    clear_counts;
    wr(`DTC_OFS_MODE, 8'h09);
    wr(`DTC_OFS_CTRL, 8'h10);
    repeat (20) @(posedge clk);
    rdc(`DTC_OFS_T0_LOW, 8'h00);
    chk({7'h0, flag[2]}, 8'h01);
    irq_a <= 1'b1;
    repeat (20) @(posedge clk);
    pulse(2);
    chk({7'h0, flag[2]}, 8'h00);
    xfer(1'b0, `DTC_OFS_T0_LOW, 8'h00);
    chk({7'h0, r != 8'h00}, 8'h01);
    // edge trigger: one set per falling edge
    wr(`DTC_OFS_CTRL, 8'h01);
    irq_a <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h0, flag[2]}, 8'h01);
    pulse(2);
    repeat (10) @(posedge clk);
    chk({7'h0, flag[2]}, 8'h00);
    irq_a <= 1'b1;
    // second request line, level trigger, cleared by its ack
    irq_b <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h0, flag[3]}, 8'h01);
    irq_b <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(3);
    chk({7'h0, flag[3]}, 8'h00);
    // both units counting pin edges
    wr(`DTC_OFS_MODE, 8'h55);
    clear_counts;
    wr(`DTC_OFS_CTRL, 8'h50);
    start <= 2'b11;
    @(posedge clk);
    start <= 2'b00;
    @(posedge clk);
    for (int i = 0; i < 300 && busy !== 2'b00; i++) @(posedge clk);
    repeat (10) @(posedge clk);
    wr(`DTC_OFS_CTRL, 8'h00);
    rdc(`DTC_OFS_T0_LOW, 8'h03);
    rdc(`DTC_OFS_T1_LOW, 8'h05);
    // split: high byte runs on the second run bit and flag
    clear_counts;
    wr(`DTC_OFS_T0_HIGH, 8'hFF);
    wr(`DTC_OFS_MODE, 8'h03);
    wr(`DTC_OFS_CTRL, 8'h40);
    poll(`DTC_OFS_CTRL, 7);
    chk({7'h0, flag[1]}, 8'h01);
    chk({7'h0, flag[0]}, 8'h00);
    rdc(`DTC_OFS_T0_LOW, 8'h00);
    pulse(1);
    chk({7'h0, flag[1]}, 8'h00);
    // run bits off: the second unit must still restart on its mode alone
    wr(`DTC_OFS_CTRL, 8'h00);
    wr(`DTC_OFS_MODE, 8'h33);
    xfer(1'b0, `DTC_OFS_T1_LOW, 8'h00);
    r2 = r;
    repeat (10) @(posedge clk);
    rdc(`DTC_OFS_T1_LOW, r2);
    wr(`DTC_OFS_MODE, 8'h03);
    repeat (10) @(posedge clk);
    xfer(1'b0, `DTC_OFS_T1_LOW, 8'h00);
    chk({7'h0, r != r2}, 8'h01);
    final_report;
  end
endmodule : dual_timer_counter_tb
